// File: include/lsd_regs.svh
`ifndef LSD_REGS_SVH
`define LSD_REGS_SVH

// ****************************************************************
// Mode codes as seen after extension
// ****************************************************************
`define LSD_MODE_LINK_ACT      5'h00
`define LSD_MODE_LINK1000_ACT  5'h01
`define LSD_MODE_LINK100_ACT   5'h02
`define LSD_MODE_LINK10_ACT    5'h03
`define LSD_MODE_LINK100G_ACT  5'h04
`define LSD_MODE_LINK10G_ACT   5'h05
`define LSD_MODE_LINK10M_ACT   5'h06
`define LSD_MODE_FIBER_ACT     5'h07
`define LSD_MODE_DUPLEX_COL    5'h08
`define LSD_MODE_COLLISION     5'h09
`define LSD_MODE_ACTIVITY      5'h0A
`define LSD_MODE_FIBER_ONLY    5'h0B
`define LSD_MODE_ANEG_FAULT    5'h0C
`define LSD_MODE_SERIAL        5'h0D
`define LSD_MODE_FORCE_OFF     5'h0E
`define LSD_MODE_FORCE_ON      5'h0F
`define LSD_MODE_LINK_BX       5'h10
`define LSD_MODE_LINK_FX       5'h11
`define LSD_MODE_ACT_BX        5'h12
`define LSD_MODE_ACT_FX        5'h13
`define LSD_MODE_XFORCE_OFF    5'h14
`define LSD_MODE_XFORCE_ON     5'h15

// ****************************************************************
// Field layout, counts and reset values
// ****************************************************************
`define LSD_EXT_BASE           5'h10
`define LSD_FIELD_W            4
`define LSD_NUM_LEDS           4
`define LSD_SERIAL_PORT        0
`define LSD_LED_OFF_LVL        1'b1

`endif

// File: include/lsd_pkg.sv
package lsd_pkg;

   // ****************************************************************
   // Link speed reported by the PHY core
   // ****************************************************************
   typedef enum logic [1:0] {
      LSD_SPD_10,
      LSD_SPD_100,
      LSD_SPD_1000
   } lsd_speed_t;

   // What one LED is asked to show
   typedef enum logic [1:0] {
      LSD_DRV_OFF,
      LSD_DRV_ON,
      LSD_DRV_BLINK
   } lsd_drive_t;

   // Port status from the PHY core
   typedef struct packed {
      logic       link_up;
      lsd_speed_t speed;
      logic       fiber;
      logic       full_duplex;
      logic       collision;
      logic       tx_act;
      logic       rx_act;
      logic       aneg_fault;
   } lsd_status_t;

   // Configuration bits shared by all LEDs of the port
   typedef struct packed {
      logic use_strap;
      logic copper_only;
      logic act_select;
      logic pulse_en;
   } lsd_cfg_t;

endpackage : lsd_pkg

// File: src/lsd_mode_sel.sv
`timescale 1ns/1ps
`default_nettype none
`include "lsd_regs.svh"

module lsd_mode_sel
   import lsd_pkg::*;
(
   input  wire logic [`LSD_FIELD_W-1:0] reg_field,
   input  wire logic [`LSD_FIELD_W-1:0] strap_field,
   input  wire logic                    use_strap,
   input  wire logic                    ext_en,
   output logic      [4:0]              eff_mode
);

   logic [`LSD_FIELD_W-1:0] field;

   // ****************************************************************
   // Field source and extension
   // ****************************************************************
   // Register field unless the straps are chosen
   assign field    = use_strap ? strap_field : reg_field;
   // Extended bit lifts the field into 16 and up
   assign eff_mode = ext_en ? (`LSD_EXT_BASE | {1'b0, field}) : {1'b0, field};

endmodule : lsd_mode_sel
`default_nettype wire

// File: src/lsd_led_drive.sv
`timescale 1ns/1ps
`default_nettype none
`include "lsd_regs.svh"

module lsd_led_drive
   import lsd_pkg::*;
(
   input  wire logic       drv,
   input  wire logic       blink,
   input  wire logic       blink_wave,
   input  wire logic       pulse_gate,
   input  wire logic       pulse_wave,
   output logic            asserted
);

   logic shown;

   // ****************************************************************
   // Steady, blinking and power-save pulsing
   // ****************************************************************
   // Blink follows the behaviour unit waveform
   assign shown    = drv | (blink & blink_wave);
   // Pulsing only chops an already lit LED
   assign asserted = shown & (~pulse_gate | pulse_wave);

endmodule : lsd_led_drive
`default_nettype wire

// File: src/lsd_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "lsd_regs.svh"

module lsd_top
   import lsd_pkg::*;
#(
   parameter int NUM_LEDS = `LSD_NUM_LEDS,
   parameter int PORT_IDX = 0
)(
   input  wire logic                                 clk_sys,
   input  wire logic                                 srst,
   input  wire logic                                 clk_en,
   input  wire lsd_status_t                          status,
   input  wire lsd_cfg_t                             cfg,
   input  wire logic [NUM_LEDS-1:0][`LSD_FIELD_W-1:0] mode_field,
   input  wire logic [NUM_LEDS-1:0][`LSD_FIELD_W-1:0] strap_config_pins,
   input  wire logic [NUM_LEDS-1:0]                  ext_en,
   input  wire logic [NUM_LEDS-1:0]                  blink_wave,
   input  wire logic                                 pulse_wave,
   output logic      [NUM_LEDS-1:0]                  led_n,
   output logic      [NUM_LEDS-1:0]                  serial_sel
);

   // ****************************************************************
   // Link and activity classes
   // ****************************************************************
   logic link_any;
   logic link_cu;
   logic link_1000;
   logic link_100;
   logic link_10;
   logic link_bx;
   logic link_fx;
   logic act_any;
   logic act_fiber;
   logic act_bx;
   logic act_fx;

   // Speed classes; 10 Mb exists on copper only
   assign link_any  = status.link_up;
   assign link_cu   = status.link_up & ~status.fiber;
   assign link_1000 = status.link_up & (status.speed == LSD_SPD_1000);
   assign link_100  = status.link_up & (status.speed == LSD_SPD_100);
   assign link_10   = link_cu & (status.speed == LSD_SPD_10);
   assign link_bx   = link_1000 & status.fiber;
   assign link_fx   = link_100 & status.fiber;

   // Activity counts either direction unless narrowed
   assign act_any   = status.tx_act | status.rx_act;
   assign act_fiber = status.link_up & status.fiber;
   assign act_bx    = link_bx & act_any;
   assign act_fx    = link_fx & act_any;

   // ****************************************************************
   // Mode decode
   // ****************************************************************
   typedef struct packed {
      logic on;
      logic blink;
   } lsd_look_t;

   // Link gate with optional activity blink, shared by modes 0 to 7
   function automatic lsd_look_t link_look(input logic lnk, input logic act);
      lsd_look_t r;
      r.on    = lnk & ~act;
      r.blink = lnk & act;
      return r;
   endfunction : link_look

   // Activity-only look: dark unless blinking
   function automatic lsd_look_t act_look(input logic act);
      lsd_look_t r;
      r.on    = 1'b0;
      r.blink = act;
      return r;
   endfunction : act_look

   // Whole table; the serial mode is dark here since the stream is elsewhere
   function automatic lsd_look_t decode(input logic [4:0] m);
      lsd_look_t r;
      r = '0;
      case (m)
         `LSD_MODE_LINK_ACT: begin
            r = link_look(cfg.copper_only ? link_cu : link_any, act_any);
         end
         `LSD_MODE_LINK1000_ACT: begin
            r = link_look(link_1000, act_any);
         end
         `LSD_MODE_LINK100_ACT: begin
            r = link_look(link_100, act_any);
         end
         `LSD_MODE_LINK10_ACT: begin
            r = link_look(link_10, act_any);
         end
         `LSD_MODE_LINK100G_ACT: begin
            r = link_look(link_100 | link_1000, act_any);
         end
         `LSD_MODE_LINK10G_ACT: begin
            r = link_look(link_10 | link_1000, act_any);
         end
         `LSD_MODE_LINK10M_ACT: begin
            r = link_look(link_10 | link_100, act_any);
         end
         `LSD_MODE_FIBER_ACT: begin
            r = link_look(link_bx | link_fx, act_any);
         end
         `LSD_MODE_DUPLEX_COL: begin
            r.on    = link_any & status.full_duplex;
            r.blink = link_any & ~status.full_duplex & status.collision;
         end
         `LSD_MODE_COLLISION: begin
            r = act_look(status.collision);
         end
         `LSD_MODE_ACTIVITY: begin
            r = act_look(cfg.act_select ? status.tx_act : act_any);
         end
         `LSD_MODE_FIBER_ONLY: begin
            r = act_look(act_fiber & (cfg.act_select ? status.rx_act : act_any));
         end
         `LSD_MODE_ANEG_FAULT: begin
            r.on = status.aneg_fault;
         end
         `LSD_MODE_FORCE_ON,
         `LSD_MODE_XFORCE_ON: begin
            r.on = 1'b1;
         end
         `LSD_MODE_LINK_BX: begin
            r.on = link_bx;
         end
         `LSD_MODE_LINK_FX: begin
            r.on = link_fx;
         end
         `LSD_MODE_ACT_BX: begin
            r = act_look(act_bx);
         end
         `LSD_MODE_ACT_FX: begin
            r = act_look(act_fx);
         end
         default: begin
            // Force off, serial, and reserved extended codes stay dark
            r = '0;
         end
      endcase
      return r;
   endfunction : decode

   // ****************************************************************
   // Per-LED datapath
   // ****************************************************************
   logic      [NUM_LEDS-1:0][4:0] eff_mode;
   lsd_look_t [NUM_LEDS-1:0]      look;
   lsd_drive_t [NUM_LEDS-1:0]     drv_kind;
   logic      [NUM_LEDS-1:0]      pulse_gate;
   logic      [NUM_LEDS-1:0]      asserted;
   logic      [NUM_LEDS-1:0]      led_n_next;
   logic      [NUM_LEDS-1:0]      led_n_reg;
   logic      [NUM_LEDS-1:0]      serial_sel_reg;

   genvar gi;
   generate
      for (gi = 0; gi < NUM_LEDS; gi = gi + 1) begin : g_led
         // Field choice and extension per LED
         lsd_mode_sel u_sel (
            .reg_field   (mode_field[gi]),
            .strap_field (strap_config_pins[gi]),
            .use_strap   (cfg.use_strap),
            .ext_en      (ext_en[gi]),
            .eff_mode    (eff_mode[gi])
         );

         // Process form so status and config changes also re-run the decode
         always_comb begin
            look[gi] = decode(eff_mode[gi]);
         end

         // Summary kind, kept for observation
         assign drv_kind[gi] = look[gi].blink ? LSD_DRV_BLINK :
                               (look[gi].on ? LSD_DRV_ON : LSD_DRV_OFF);

         // Mode 21 is the one forced-on code that never pulses
         assign pulse_gate[gi] = cfg.pulse_en &&
                                 (eff_mode[gi] != `LSD_MODE_XFORCE_ON);

         lsd_led_drive u_drv (
            .drv        (look[gi].on),
            .blink      (look[gi].blink),
            .blink_wave (blink_wave[gi]),
            .pulse_gate (pulse_gate[gi]),
            .pulse_wave (pulse_wave),
            .asserted   (asserted[gi])
         );

         // Active low pin level
         assign led_n_next[gi] = ~asserted[gi];
      end
   endgenerate

   // ****************************************************************
   // Output registers
   // ****************************************************************
   // Pins are registered so glitches of the decode never reach the LEDs
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         led_n_reg <= {NUM_LEDS{`LSD_LED_OFF_LVL}};
      end else if (clk_en) begin
         led_n_reg <= led_n_next;
      end
   end

   // Serial hand-off flag, honoured on port 0 only
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         serial_sel_reg <= '0;
      end else if (clk_en) begin
         for (int i = 0; i < NUM_LEDS; i++) begin
            serial_sel_reg[i] <= (PORT_IDX == `LSD_SERIAL_PORT) &&
                                 (eff_mode[i] == `LSD_MODE_SERIAL);
         end
      end
   end

   assign led_n      = led_n_reg;
   assign serial_sel = serial_sel_reg;

   // Delayed link class for the gigabit check, frozen with the rest
   logic link_1000_d;
   always_ff @(posedge clk_sys) begin
      if (clk_en) begin
         link_1000_d <= link_1000;
      end
   end

   // ****************************************************************
   // Assertions
   // ****************************************************************
   default clocking cb @(posedge clk_sys); endclocking

   // Reset held, then released with the clock running
   sequence s_reset_release;
      srst ##1 (!srst && clk_en);
   endsequence

   a_reset_dark: assert property (srst |=> led_n == '1)
      else $error("LEDs not dark after reset");

   a_release_resume: assert property (s_reset_release |=> led_n == $past(led_n_next))
      else $error("LED decode did not resume after reset");

   a_freeze_hold: assert property (disable iff (srst)
      !clk_en |=> $stable(led_n))
      else $error("LED changed while clock enable low");

   generate
      for (gi = 0; gi < NUM_LEDS; gi = gi + 1) begin : g_chk
         // Mode m selected with the clock enabled and no pulsing; each check but a_ext_map looks at the next cycle
         sequence s_solid(int m);
            clk_en && !cfg.pulse_en && eff_mode[gi] == 5'(m);
         endsequence

         a_mode0_link: assert property (disable iff (srst)
            s_solid(0) ##0 (!cfg.copper_only && status.link_up && !act_any)
            |=> !led_n[gi])
            else $error("mode 0 link did not light LED");

         a_mode0_copper: assert property (disable iff (srst)
            s_solid(0) ##0 (cfg.copper_only && status.fiber)
            |=> led_n[gi])
            else $error("mode 0 showed fiber link under copper-only");

         a_mode1_gig: assert property (disable iff (srst)
            s_solid(1) ##0 (!act_any)
            |=> led_n[gi] == !link_1000_d)
            else $error("mode 1 level wrong");

         a_mode3_ten: assert property (disable iff (srst)
            s_solid(3) ##0 (status.link_up && status.fiber) |=> led_n[gi])
            else $error("mode 3 lit for fiber link");

         a_mode8_dup: assert property (disable iff (srst)
            s_solid(8) ##0 (status.link_up && status.full_duplex) |=> !led_n[gi])
            else $error("mode 8 full duplex not lit");

         a_mode9_quiet: assert property (disable iff (srst)
            s_solid(9) ##0 (!status.collision) |=> led_n[gi])
            else $error("mode 9 lit without collision");

         a_mode10_tx: assert property (disable iff (srst)
            s_solid(10) ##0 (cfg.act_select && !status.tx_act) |=> led_n[gi])
            else $error("mode 10 counted receive under select");

         a_mode12_fault: assert property (disable iff (srst)
            s_solid(12) |=> led_n[gi] == !$past(status.aneg_fault))
            else $error("mode 12 level wrong");

         a_force_off: assert property (disable iff (srst)
            clk_en && (eff_mode[gi] == `LSD_MODE_FORCE_OFF ||
                       eff_mode[gi] == `LSD_MODE_XFORCE_OFF) |=> led_n[gi])
            else $error("forced-off LED lit");

         a_force_on_np: assert property (disable iff (srst)
            clk_en && eff_mode[gi] == `LSD_MODE_XFORCE_ON |=> !led_n[gi])
            else $error("mode 21 LED not solidly lit");

         a_ext_map: assert property (disable iff (srst)
            ext_en[gi] && !cfg.use_strap
            |-> eff_mode[gi] == {1'b1, mode_field[gi]})
            else $error("extended mode not 16 plus field");

         a_mode17_fx: assert property (disable iff (srst)
            s_solid(17) |=> led_n[gi] == !$past(link_fx))
            else $error("mode 17 level wrong");

         a_blink_follow: assert property (disable iff (srst)
            clk_en && !cfg.pulse_en && drv_kind[gi] == LSD_DRV_BLINK
            |=> led_n[gi] == !$past(blink_wave[gi]))
            else $error("blink did not follow waveform");

         a_serial_port: assert property (disable iff (srst)
            clk_en && eff_mode[gi] == `LSD_MODE_SERIAL
            |=> serial_sel[gi] == (PORT_IDX == `LSD_SERIAL_PORT))
            else $error("serial hand-off flag wrong for this port");
      end
   endgenerate

endmodule : lsd_top
`default_nettype wire

// File: sim/lsd_led_bank.sv
`timescale 1ns/1ps
`default_nettype none

// ****************************************************************
// Discrete LEDs wired cathode to pin, anode to supply
// ****************************************************************
module lsd_led_bank #(
   parameter int NUM_LEDS = 4
)(
   input  wire logic [NUM_LEDS-1:0] led_n,
   output logic      [NUM_LEDS-1:0] lit
);
   // Current only flows when the pin sinks, so low means lit
   assign lit = ~led_n;
endmodule : lsd_led_bank

`default_nettype wire

// File: sim/led_status_mode_decoder_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "lsd_regs.svh"

module led_status_mode_decoder_tb
   import lsd_pkg::*;
;
   logic                   clk_sys;
   logic                   srst;
   logic                   clk_en;
   lsd_status_t            status;
   lsd_cfg_t               cfg;
   logic [3:0][3:0]        mode_field;
   logic [3:0][3:0]        strap_config_pins;
   logic [3:0]             ext_en;
   logic [3:0]             blink_wave;
   logic                   pulse_wave;
   logic [3:0]             led_n;
   logic [3:0]             serial_sel;
   logic [3:0]             lit;
   logic [3:0]             led_n_p1;
   logic [3:0]             serial_sel_p1;
   logic [3:0][4:0]        modes;
   lsd_status_t            st_tab [8];
   int                     n_fail;
   int                     n_compared;

   lsd_top dut (.clk_sys(clk_sys), .srst(srst), .clk_en(clk_en), .status(status),
      .cfg(cfg), .mode_field(mode_field), .strap_config_pins(strap_config_pins),
      .ext_en(ext_en), .blink_wave(blink_wave), .pulse_wave(pulse_wave),
      .led_n(led_n), .serial_sel(serial_sel));

   // Second port, where the serial code must stay reserved
   lsd_top #(.PORT_IDX(1)) dut_p1 (.clk_sys(clk_sys), .srst(srst), .clk_en(clk_en),
      .status(status), .cfg(cfg), .mode_field(mode_field),
      .strap_config_pins(strap_config_pins), .ext_en(ext_en), .blink_wave(blink_wave),
      .pulse_wave(pulse_wave), .led_n(led_n_p1), .serial_sel(serial_sel_p1));

   lsd_led_bank #(.NUM_LEDS(4)) leds (.led_n(led_n), .lit(lit));

   // ****************************************************************
   // Clock and checking helpers
   // ****************************************************************
   initial clk_sys = 1'b0;
   always #2 clk_sys = ~clk_sys;

   task automatic check(input string what, input logic [3:0] exp, input logic [3:0] got);
      n_compared++;
      if (got !== exp) begin
         n_fail++;
         $display("unexpected %s expected %b seen %b", what, exp, got);
      end
   endtask : check

   task automatic report_and_stop();
      $display("compared %0d mismatches %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : report_and_stop

   // Field goes to the chosen source, the other gets its inverse as a decoy
   task automatic drive_modes();
      for (int i = 0; i < 4; i++) begin
         ext_en[i]            = modes[i][4];
         mode_field[i]        = cfg.use_strap ? ~modes[i][3:0] : modes[i][3:0];
         strap_config_pins[i] = cfg.use_strap ? modes[i][3:0] : ~modes[i][3:0];
      end
   endtask : drive_modes

   // Reference decode; activity turns a steady link indication into blinking
   function automatic logic exp_lit(input logic [4:0] m, input lsd_status_t s,
                                    input lsd_cfg_t c, input logic bw, input logic pw);
      logic l, f, g, h, t, a, sel, on, blk;
      l = s.link_up;
      f = s.fiber;
      g = s.speed == LSD_SPD_1000;
      h = s.speed == LSD_SPD_100;
      t = (s.speed == LSD_SPD_10) & ~f;
      a = s.tx_act | s.rx_act;
      sel = 1'b0;
      on = 1'b0;
      blk = 1'b0;
      case (m)
         5'h00: sel = l & ~(c.copper_only & f);
         5'h01: sel = l & g;
         5'h02: sel = l & h;
         5'h03: sel = l & t;
         5'h04: sel = l & (h | g);
         5'h05: sel = l & (t | g);
         5'h06: sel = l & (t | h);
         5'h07: sel = l & f & (h | g);
         5'h08: begin
            on  = l & s.full_duplex;
            blk = l & ~s.full_duplex & s.collision;
         end
         5'h09: blk = s.collision;
         5'h0A: blk = c.act_select ? s.tx_act : a;
         5'h0B: blk = l & f & (c.act_select ? s.rx_act : a);
         5'h0C: on = s.aneg_fault;
         5'h0F, 5'h15: on = 1'b1;
         5'h10: on = l & f & g;
         5'h11: on = l & f & h;
         5'h12: blk = l & f & g & a;
         5'h13: blk = l & f & h & a;
         default: on = 1'b0;
      endcase
      if (m <= 5'h07) begin
         on  = sel & ~a;
         blk = sel & a;
      end
      return (on | (blk & bw)) & (~(c.pulse_en & (m != 5'h15)) | pw);
   endfunction : exp_lit

   // ****************************************************************
   // Main sequence
   // ****************************************************************
   initial begin
      logic [3:0] e_lit;
      logic [3:0] e_ser;
      n_fail = 0;
      n_compared = 0;
      srst = 1'b1;
      clk_en = 1'b1;
      status = '0;
      cfg = '0;
      modes = '0;
      blink_wave = '0;
      pulse_wave = 1'b0;
      drive_modes();
      st_tab[0] = '{1'b0, LSD_SPD_10, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 1'b1};
      st_tab[1] = '{1'b1, LSD_SPD_1000, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0};
      st_tab[2] = '{1'b1, LSD_SPD_1000, 1'b1, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0};
      st_tab[3] = '{1'b1, LSD_SPD_100, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0};
      st_tab[4] = '{1'b1, LSD_SPD_100, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0};
      st_tab[5] = '{1'b1, LSD_SPD_10, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0};
      st_tab[6] = '{1'b1, LSD_SPD_10, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1};
      st_tab[7] = '{1'b1, LSD_SPD_1000, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0};
      repeat (12) @(posedge clk_sys);
      #1;
      check("led_n in reset", 4'hF, led_n);
      srst = 1'b0;
      // Every mode code on every LED, against each status and config mix
      for (int c = 0; c < 16; c++) begin
         for (int s = 0; s < 8; s++) begin
            for (int m = 0; m < 32; m++) begin
               cfg = lsd_cfg_t'(c[3:0]);
               status = st_tab[s];
               pulse_wave = m[1] ^ s[0];
               for (int i = 0; i < 4; i++) begin
                  modes[i] = 5'((m + 8 * i) % 32);
                  blink_wave[i] = m[i] ^ c[0];
                  e_lit[i] = exp_lit(modes[i], status, cfg, blink_wave[i], pulse_wave);
                  e_ser[i] = modes[i] == 5'h0D;
               end
               drive_modes();
               @(posedge clk_sys);
               #1;
               check("lit", e_lit, lit);
               check("serial_sel", e_ser, serial_sel);
               check("lit port 1", e_lit, ~led_n_p1);
               check("serial_sel port 1", 4'h0, serial_sel_p1);
            end
         end
      end
      // Reset in mid-run overrides a forced-on LED even with the clock enable low
      cfg = '0;
      modes = {4{5'h0F}};
      drive_modes();
      @(posedge clk_sys);
      #1;
      check("lit forced", 4'hF, lit);
      srst = 1'b1;
      clk_en = 1'b0;
      @(posedge clk_sys);
      #1;
      check("led_n mid reset", 4'hF, led_n);
      check("serial_sel mid reset", 4'h0, serial_sel);
      srst = 1'b0;
      clk_en = 1'b1;
      @(posedge clk_sys);
      #1;
      check("lit after reset", 4'hF, lit);
      // Frozen outputs while the enable is low
      clk_en = 1'b0;
      modes = {4{5'h0E}};
      drive_modes();
      repeat (3) @(posedge clk_sys);
      #1;
      check("lit frozen", 4'hF, lit);
      clk_en = 1'b1;
      @(posedge clk_sys);
      #1;
      check("lit forced off", 4'h0, lit);
      report_and_stop();
   end

   // Hang guard, well beyond the roughly 16.5 us the sequence needs
   initial begin
      #200000;
      n_fail++;
      report_and_stop();
   end
endmodule : led_status_mode_decoder_tb

`default_nettype wire
